// ---- logic/adc_seq_cfg.svh ----
// timing and encoding constants for the conversion clock sequencer
// assumes a 200 MHz system clock; included by bare name
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
`define CLK_PERIOD_PS 5000
`define RC_PERIOD_PS 1600000
`define RC_HALF_CYCLES ((`RC_PERIOD_PS / `CLK_PERIOD_PS) / 2)
`define SEL_DIV2 3'h0
`define SEL_DIV4 3'h4
`define SEL_DIV8 3'h1
`define SEL_DIV16 3'h5
`define SEL_DIV32 3'h2
`define SEL_DIV64 3'h6
`define SEL_RC_LOW 2'h3
`define HALF_PERIODS_TOTAL 5'h17
`define HOLD_RELEASE_HALF 5'h01
`define RESULT_WIDTH 10
`define RESULT_MSB 4'h9
`define RESULT_ZERO 10'h000
`define RC_WIDTH 12
`define DIV_WIDTH 6
`define DIV2_HALF_LAST 6'h00
`define DIV4_HALF_LAST 6'h01
`define DIV8_HALF_LAST 6'h03
`define DIV16_HALF_LAST 6'h07
`define DIV32_HALF_LAST 6'h0F
`define DIV64_HALF_LAST 6'h1F
`define RESULT_DONE_IDX 4'hF
`endif

// ---- logic/adc_seq_pkg.sv ----
// types shared by the conversion clock sequencer
// assumes adc_seq_cfg.svh for widths
`include "adc_seq_cfg.svh"
package adc_seq_pkg;
    typedef enum logic [1:0] {st_idle, st_convert, st_finish} seq_state_t;
    typedef struct packed {
        logic [`RESULT_WIDTH-1:0] value;
        logic valid;
    } result_t;
endpackage

// ---- logic/rc_conv_clock.sv ----
// internal rc conversion oscillator, modelled as a free counter
// assumes it runs free from reset, independent of the selected divider
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_cfg.svh"
module rc_conv_clock #(
    parameter int HALF_CYCLES = `RC_HALF_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // half period strobe
    output logic half_tick
);
    localparam logic [`RC_WIDTH-1:0] LAST =
        `RC_WIDTH'(HALF_CYCLES - 1);
    logic [`RC_WIDTH-1:0] count;
    logic [`RC_WIDTH-1:0] next_count;

    initial begin
        if (HALF_CYCLES < 1 || HALF_CYCLES >= (1 << `RC_WIDTH))
            $error("rc half period out of range");
    end

    // free running, so the bit period never follows the divider
    always_comb begin
        next_count = (count == LAST) ? '0 : count + 1'b1;
    end

    always_ff @(posedge clock) begin
        if (sys_rst)
            count <= '0;
        else
            count <= next_count;
    end

    assign half_tick = (count == LAST);
endmodule
`default_nettype wire

// ---- logic/adc_conv_seq.sv ----
// conversion clock selection and bit sequencing for a 10-bit sar converter
// assumes the comparator output is asynchronous; start and select are sync
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_cfg.svh"
// Summary of operation
// - select field picks system divider 2..64 or the rc oscillator (x11)
// - rc bit period comes from a dedicated oscillator, 1.0 to 6.0 us
// - rc bit period is typically 1.6 us
// - a full conversion lasts 11.5 bit periods
// - one bit resolved per period, b9 first, b0 last
// - divided sources track the system clock proportionally
// - sleep conversions use the rc source; sleep_mode forces it whatever the select
// - at end load result pair, clear request, set done, reconnect cap
module adc_conv_seq (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // configuration
    input wire logic [2:0] conversion_clock_select,
    input wire logic sleep_mode,
    // software request and status
    input wire logic conv_request_set,
    input wire logic done_flag_clear,
    output logic conv_request,
    output logic conversion_done_flag,
    output adc_seq_pkg::result_t result_register_pair,
    // analog side
    input wire logic comparator_out,
    output logic hold_disconnect,
    output logic [`RESULT_WIDTH-1:0] dac_trial
);
    import adc_seq_pkg::*;

    logic half_rc;
    logic [`DIV_WIDTH-1:0] div_cnt;
    logic [`DIV_WIDTH-1:0] next_div_cnt;
    logic [`DIV_WIDTH-1:0] div_last;
    logic half_tick;
    logic use_rc;
    logic cmp_meta;
    logic cmp_sync;
    seq_state_t state;
    seq_state_t next_state;
    logic [4:0] half_cnt;
    logic [4:0] next_half_cnt;
    logic [`RESULT_WIDTH-1:0] sar;
    logic [`RESULT_WIDTH-1:0] next_sar;
    logic [3:0] bit_idx;
    logic [3:0] next_bit_idx;
    logic next_request;
    logic next_done;
    result_t next_result;
    logic next_hold;
    logic [`RESULT_WIDTH-1:0] next_trial;

    rc_conv_clock u_rc (
        .clock(clock),
        .sys_rst(sys_rst),
        .half_tick(half_rc)
    );

    // rc chosen whenever the low two bits are both set; forced in sleep
    assign use_rc = (conversion_clock_select[1:0] == `SEL_RC_LOW) |
                    sleep_mode;

    // half bit period less one, in system clocks; tad = 2 * half
    always_comb begin
        case (conversion_clock_select)
            `SEL_DIV2: div_last = `DIV2_HALF_LAST;
            `SEL_DIV4: div_last = `DIV4_HALF_LAST;
            `SEL_DIV8: div_last = `DIV8_HALF_LAST;
            `SEL_DIV16: div_last = `DIV16_HALF_LAST;
            `SEL_DIV32: div_last = `DIV32_HALF_LAST;
            `SEL_DIV64: div_last = `DIV64_HALF_LAST;
            default: div_last = `DIV2_HALF_LAST;
        endcase
        next_div_cnt = (state == st_idle || div_cnt >= div_last) ?
                       '0 : div_cnt + 1'b1;
    end

    always_ff @(posedge clock) begin
        if (sys_rst)
            div_cnt <= '0;
        else
            div_cnt <= next_div_cnt;
    end

    // divider restarts at idle so the first period is a whole one
    assign half_tick = use_rc ? half_rc :
                       (state != st_idle && div_cnt >= div_last);

    // comparator crosses from the analog domain; bit periods under three
    // clocks outrun this lag and resolve on a stale trial
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            cmp_meta <= comparator_out;
            cmp_sync <= cmp_meta;
        end
    end

    // sequencer: 23 half periods = 11.5 tad, bits b9..b0 in tad2..tad11
    always_comb begin
        next_state = state;
        next_half_cnt = half_cnt;
        next_sar = sar;
        next_bit_idx = bit_idx;
        next_request = conv_request | conv_request_set;
        next_done = conversion_done_flag;
        next_result = result_register_pair;
        next_hold = hold_disconnect;
        if (done_flag_clear)
            next_done = 1'b0;
        case (state)
            st_idle: begin
                if (conv_request | conv_request_set) begin
                    next_state = st_convert;
                    next_half_cnt = '0;
                    next_sar = `RESULT_ZERO;
                    next_bit_idx = `RESULT_MSB;
                end
            end
            st_convert: begin
                if (half_tick) begin
                    next_half_cnt = half_cnt + 5'h01;
                    // release hold early in the first period
                    if (half_cnt == `HOLD_RELEASE_HALF - 5'h01)
                        next_hold = 1'b1;
                    // odd half ends a trial; resolve one bit msb first
                    if (half_cnt[0] && half_cnt > 5'h01 &&
                        bit_idx <= `RESULT_MSB) begin
                        next_sar[bit_idx] = cmp_sync;
                        next_bit_idx = bit_idx - 4'h1;
                    end
                    if (half_cnt == `HALF_PERIODS_TOTAL - 5'h01)
                        next_state = st_finish;
                end
            end
            st_finish: begin
                // set wins over a clear in the same cycle
                next_result.value = sar;
                next_result.valid = 1'b1;
                next_request = 1'b0;
                next_done = 1'b1;
                next_hold = 1'b0;
                next_state = st_idle;
            end
            default: next_state = st_idle;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= st_idle;
            half_cnt <= '0;
            sar <= `RESULT_ZERO;
            bit_idx <= `RESULT_MSB;
            conv_request <= 1'b0;
            conversion_done_flag <= 1'b0;
            result_register_pair <= '0;
            hold_disconnect <= 1'b0;
            dac_trial <= `RESULT_ZERO;
        end else begin
            state <= next_state;
            half_cnt <= next_half_cnt;
            sar <= next_sar;
            bit_idx <= next_bit_idx;
            conv_request <= next_request;
            conversion_done_flag <= next_done;
            result_register_pair <= next_result;
            hold_disconnect <= next_hold;
            dac_trial <= next_trial;
        end
    end

    // trial word: resolved bits plus the bit under test, registered
    always_comb begin
        next_trial = next_sar;
        if (next_state == st_convert && next_bit_idx <= `RESULT_MSB)
            next_trial[next_bit_idx] = 1'b1;
    end

    property p_finish_flags;
        @(posedge clock) disable iff (sys_rst)
        state == st_finish |=> conversion_done_flag && !conv_request &&
            !hold_disconnect && result_register_pair.value == $past(sar);
    endproperty
    a_finish_flags: assert property (p_finish_flags)
        else $error("end of conversion flags wrong");

    property p_length;
        @(posedge clock) disable iff (sys_rst)
        state == st_convert |-> half_cnt < `HALF_PERIODS_TOTAL;
    endproperty
    a_length: assert property (p_length)
        else $error("conversion overran its half periods");

    property p_msb_first;
        @(posedge clock) disable iff (sys_rst)
        $rose(state == st_convert) |-> bit_idx == `RESULT_MSB;
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("conversion did not begin at msb");

    property p_bit_done;
        @(posedge clock) disable iff (sys_rst)
        state == st_finish |-> bit_idx == `RESULT_DONE_IDX;
    endproperty
    a_bit_done: assert property (p_bit_done)
        else $error("not all ten bits resolved");

    property p_start;
        @(posedge clock) disable iff (sys_rst)
        state == st_idle && conv_request_set |=> state == st_convert;
    endproperty
    a_start: assert property (p_start)
        else $error("request did not start conversion");

    property p_hold;
        @(posedge clock) disable iff (sys_rst)
        state == st_convert && half_cnt > `HOLD_RELEASE_HALF
            |-> hold_disconnect;
    endproperty
    a_hold: assert property (p_hold)
        else $error("capacitor not held during conversion");

    property p_rc_select;
        @(posedge clock) disable iff (sys_rst)
        state == st_convert && conversion_clock_select[1:0] == `SEL_RC_LOW &&
            !half_rc |=> half_cnt == $past(half_cnt);
    endproperty
    a_rc_select: assert property (p_rc_select)
        else $error("rc source not used for x11");

    property p_sleep_rc;
        @(posedge clock) disable iff (sys_rst)
        state == st_convert && sleep_mode && !half_rc
            |=> half_cnt == $past(half_cnt);
    endproperty
    a_sleep_rc: assert property (p_sleep_rc)
        else $error("sleep conversion not on rc source");

    property p_div2;
        @(posedge clock) disable iff (sys_rst)
        state == st_convert && !sleep_mode &&
            conversion_clock_select == `SEL_DIV2
            |=> half_cnt == $past(half_cnt) + 5'h01;
    endproperty
    a_div2: assert property (p_div2)
        else $error("divide by two source not tracking clock");
endmodule
`default_nettype wire

// ---- tb/sar_analog_model.sv ----
// sample-and-hold plus comparator facing the sequencer's analog side
// assumes analog_in is a 10-bit code driven by the bench
`timescale 1ns/10ps
`default_nettype none
module sar_analog_model (
    // clock
    input wire logic clock,
    // sequencer side
    input wire logic hold_disconnect,
    input wire logic [9:0] dac_trial,
    output logic comparator_out,
    // bench side
    input wire logic [9:0] analog_in
);
    logic [9:0] held = 10'h000;
    // cap tracks the input only while connected
    always @(posedge clock) begin
        if (!hold_disconnect)
            held <= analog_in;
    end
    // keep trial bit while trial code is not above the held level
    assign comparator_out = (dac_trial <= held);
endmodule
`default_nettype wire

// ---- tb/adc_conv_seq_tb.sv ----
// self-checking bench for the conversion clock sequencer
// assumes the rc oscillator keeps its default 160-cycle half period
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_cfg.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module adc_conv_seq_tb;
    import adc_seq_pkg::*;
    logic clock = 1'b0, sys_rst = 1'b1, sleep_mode = 1'b0;
    logic [2:0] conversion_clock_select = 3'h0;
    logic conv_request_set = 1'b0, done_flag_clear = 1'b0;
    logic conv_request, conversion_done_flag, comparator_out;
    logic hold_disconnect, seen = 1'b0, in_range;
    logic [9:0] dac_trial, analog_in = 10'h000, ev;
    result_t result_register_pair;
    int n_fail = 0, tests_run = 0, cyc = 0, lo, hi, k;
    // half periods per select code; each divider at its real length
    int halves[8] = '{1, 4, 16, `RC_HALF_CYCLES, 2, 8, 32, `RC_HALF_CYCLES};
    logic [9:0] exp_val[$];
    int exp_lo[$], exp_hi[$];

    adc_conv_seq DUT (.clock(clock), .sys_rst(sys_rst),
        .conversion_clock_select(conversion_clock_select),
        .sleep_mode(sleep_mode), .conv_request_set(conv_request_set),
        .done_flag_clear(done_flag_clear), .conv_request(conv_request),
        .conversion_done_flag(conversion_done_flag),
        .result_register_pair(result_register_pair),
        .comparator_out(comparator_out),
        .hold_disconnect(hold_disconnect), .dac_trial(dac_trial));
    sar_analog_model analog (.clock(clock), .hold_disconnect(hold_disconnect),
        .dac_trial(dac_trial), .comparator_out(comparator_out),
        .analog_in(analog_in));

    // 200 MHz clock and a free cycle count for latency checks
    initial begin
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) cyc <= cyc + 1;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one conversion; the expectation is noted before it can finish
    task automatic run_conv(input logic [2:0] sel, input logic slp,
                            input int half);
        logic [9:0] v;
        int i;
        v = 10'($urandom);
        // a one-clock half period is below the minimum bit period and
        // shorter than the comparator sync lag only all-equal
        // codes survive stale decisions there
        if (half < 2)
            v = {10{v[0]}};
        @(posedge clock);
        conversion_clock_select <= sel;
        sleep_mode <= slp;
        analog_in <= v;
        conv_request_set <= 1'b1;
        @(posedge clock);
        conv_request_set <= 1'b0;
        exp_val.push_back(v);
        // rc phase is free running, so only a window is fair there
        exp_lo.push_back(cyc + (half == `RC_HALF_CYCLES ?
                                22 * half + 3 : 23 * half + 2));
        exp_hi.push_back(cyc + 23 * half + 2);
        // cap opens after the first half period, whatever its phase
        repeat (half + 4) @(posedge clock);
        @(negedge clock);
        `CHK(hold_disconnect, 1'b1)
        `CHK(conv_request, 1'b1)
        @(posedge clock);
        analog_in <= ~v; // input moves; held sample must win
        i = 0;
        while (conversion_done_flag !== 1'b1 && i < 5000) begin
            @(posedge clock);
            i++;
        end
        // a conversion that never ends is a mismatch
        if (i >= 5000)
            n_fail++;
        @(posedge clock);
        done_flag_clear <= 1'b1;
        @(posedge clock);
        done_flag_clear <= 1'b0;
        @(negedge clock);
        `CHK(conversion_done_flag, 1'b0)
    endtask

    // monitor: first cycle of done pops the oldest note
    always @(posedge clock) begin
        if (conversion_done_flag === 1'b1 && !seen && exp_val.size() > 0) begin
            seen = 1'b1;
            ev = exp_val.pop_front();
            lo = exp_lo.pop_front();
            hi = exp_hi.pop_front();
            in_range = (cyc >= lo) && (cyc <= hi);
            `CHK(result_register_pair.value, ev)
            `CHK(result_register_pair.valid, 1'b1)
            `CHK(conv_request, 1'b0)
            `CHK(hold_disconnect, 1'b0)
            `CHK(in_range, 1'b1)
        end else if (conversion_done_flag !== 1'b1) begin
            seen = 1'b0;
        end
    end

    initial begin
        #(60000 * 5);
        n_fail++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h628be357));
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        `CHK(conversion_done_flag, 1'b0)
        `CHK(result_register_pair, 11'h000)
        // every select code, including both rc encodings
        for (k = 0; k < 8; k++) begin
            run_conv(3'(k), 1'b0, halves[k]);
        end
        run_conv(3'h0, 1'b1, `RC_HALF_CYCLES);
        `CHK(exp_val.size(), 0)
        end_of_test();
    end
endmodule
`default_nettype wire
